// File: rtl/pifp_defines.vh
// Offsets, field positions, reset values and timing counts for the interrupt flag block
`ifndef PIFP_DEFINES_VH
`define PIFP_DEFINES_VH
// Register offsets (word index on the plain port)
`define PIFP_ADDR_W 4
`define PIFP_OFF_FLAGS_ONE 4'h0
`define PIFP_OFF_FLAGS_TWO 4'h1
`define PIFP_OFF_ENABLES_ONE 4'h2
`define PIFP_OFF_ENABLES_TWO 4'h3
`define PIFP_OFF_PRIORITY_ONE 4'h4
`define PIFP_OFF_PRIORITY_TWO 4'h5
`define PIFP_OFF_CORE_CTRL 4'h6
`define PIFP_OFF_CORE_FLAGS 4'h7
`define PIFP_OFF_CORE_PRIO 4'h8
`define PIFP_OFF_STATUS 4'h9
// Reset values
`define PIFP_RST_FLAGS 8'h00
`define PIFP_RST_ENABLES 8'h00
`define PIFP_RST_PRIORITY_ONE 8'h7F
`define PIFP_RST_PRIORITY_TWO 8'h0F
`define PIFP_RST_CORE_CTRL 8'h00
`define PIFP_RST_CORE_PRIO 8'h3F
// Implemented-bit masks
`define PIFP_MASK_ONE 8'h7F
`define PIFP_MASK_TWO 8'h0F
// Core control fields
`define PIFP_CC_GIE 7
`define PIFP_CC_PERIPHERAL_IRQ_ENABLE 6
`define PIFP_CC_T0IE 5
`define PIFP_CC_PBIE 4
`define PIFP_CC_X0IE 3
`define PIFP_CC_X1IE 2
`define PIFP_CC_X2IE 1
`define PIFP_CC_PLEN 0
// Core flag fields
`define PIFP_CF_T0 0
`define PIFP_CF_PB 1
`define PIFP_CF_X0 2
`define PIFP_CF_X1 3
`define PIFP_CF_X2 4
// Core priority/edge fields
`define PIFP_CP_T0IP 0
`define PIFP_CP_PBIP 1
`define PIFP_CP_X1IP 2
`define PIFP_CP_X2IP 3
`define PIFP_CP_EDGE0 4
`define PIFP_CP_EDGE1 5
`define PIFP_CP_EDGE2 6
// Timer-0 wrap values
`define PIFP_T0_WRAP8 8'hFF
`define PIFP_T0_WRAP16 16'hFFFF
// Synchroniser length in clocks
`define PIFP_SYNC_STAGES 2
`endif

// File: rtl/pifp_shadow.v
// Single-level fast return shadow for working, status and bank-select registers
`timescale 1ns/10ps
module pifp_shadow (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire capture_i,
    input wire [7:0] working_register_i,
    input wire [7:0] status_i,
    input wire [7:0] bank_select_register_i,
    output reg [23:0] shadow_o
);
    // Capture on interrupt entry; one level only, a nested entry overwrites
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shadow_o <= 24'h000000;
        end else if (capture_i) begin
            shadow_o <= {bank_select_register_i, status_i, working_register_i};
        end
    end
endmodule

// File: rtl/pifp_top.v
// Peripheral interrupt flags, enables, priorities, external and core sources
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "pifp_defines.vh"
module pifp_top (
    input wire clk_sys_i,
    input wire rst_b_i,
    // Register port
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // Peripheral event pulses (same clock)
    input wire adc_done_evt_i,
    input wire serial_rx_full_i,
    input wire serial_tx_empty_i,
    input wire sync_port_evt_i,
    input wire ccp1_evt_i,
    input wire timer2_match_evt_i,
    input wire timer1_ovf_evt_i,
    input wire bus_collision_evt_i,
    input wire low_voltage_evt_i,
    input wire timer3_ovf_evt_i,
    input wire ccp2_evt_i,
    input wire ccp2_pwm_mode_i,
    // Timer-0 count and mode
    input wire timer0_tick_i,
    input wire [15:0] timer0_count_i,
    input wire timer0_16bit_i,
    // Pins
    input wire [2:0] ext_irq_pin_i,
    input wire [3:0] port_b_hi_pin_i,
    // Core side
    input wire sleep_i,
    input wire irq_ack_i,
    input wire [20:0] return_pc_i,
    input wire [7:0] working_register_i,
    input wire [7:0] status_i,
    input wire [7:0] bank_select_register_i,
    output reg irq_high_o,
    output reg irq_low_o,
    output reg wake_o,
    output reg vector_en_o,
    output reg stack_push_o,
    output reg [20:0] stack_pc_o,
    output reg [23:0] fast_shadow_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Edge detection by selected polarity
    function edge_hit;
        input cur;
        input prev;
        input rising;
        begin
            edge_hit = rising ? (cur & ~prev) : (~cur & prev);
        end
    endfunction
    // Sticky update: set wins over software clear
    function [7:0] sticky;
        input [7:0] cur;
        input [7:0] set;
        input wr;
        input [7:0] wdata;
        input [7:0] mask;
        begin
            sticky = ((wr ? wdata : cur) | set) & mask;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0] flags_one_r;
    reg [7:0] peripheral_flags_two_r;
    reg [7:0] peripheral_enables_one_r;
    reg [7:0] peripheral_enables_two_r;
    reg [7:0] peripheral_priority_one_r;
    reg [7:0] peripheral_priority_two_r;
    reg [7:0] core_ctrl_r;
    reg [7:0] core_flags_r;
    reg [7:0] core_prio_r;
    reg [2:0] ext_meta_r;
    reg [2:0] ext_sync_r;
    reg [2:0] ext_prev_r;
    reg [3:0] pb_meta_r;
    reg [3:0] pb_sync_r;
    reg [3:0] pb_prev_r;
    reg pin_prev_valid_r;
    reg [1:0] pin_fill_r;
    reg [2:0] ext_en_sleep_r;
    reg sleep_prev_r;
    wire [23:0] fast_shadow_w;

    ////////////////////////////////////////////////////////////////////////////////
    // Event collection
    wire wr_any = reg_wr_i;
    wire [7:0] set_one;
    wire [7:0] set_two;
    wire [7:0] set_core;
    wire [2:0] ext_edge;
    wire pb_change;
    wire t0_wrap;
    // first flag sources; CCP events are timer-1 based
    assign set_one = {1'b0, adc_done_evt_i, serial_rx_full_i, serial_tx_empty_i,
                      sync_port_evt_i, ccp1_evt_i, timer2_match_evt_i, timer1_ovf_evt_i};
    // second flag sources, CCP2 ignored in PWM
    assign set_two = {4'h0, bus_collision_evt_i, low_voltage_evt_i, timer3_ovf_evt_i,
                      ccp2_evt_i & ~ccp2_pwm_mode_i};
    assign ext_edge[0] = pin_prev_valid_r &
        edge_hit(ext_sync_r[0], ext_prev_r[0], core_prio_r[`PIFP_CP_EDGE0]);
    assign ext_edge[1] = pin_prev_valid_r &
        edge_hit(ext_sync_r[1], ext_prev_r[1], core_prio_r[`PIFP_CP_EDGE1]);
    assign ext_edge[2] = pin_prev_valid_r &
        edge_hit(ext_sync_r[2], ext_prev_r[2], core_prio_r[`PIFP_CP_EDGE2]);
    assign pb_change = pin_prev_valid_r & (|(pb_sync_r ^ pb_prev_r));
    // wrap at the tick leaving the all-ones count
    assign t0_wrap = timer0_tick_i & (timer0_16bit_i ?
        (timer0_count_i == `PIFP_T0_WRAP16) : (timer0_count_i[7:0] == `PIFP_T0_WRAP8));
    // flags collect with no enable in the path
    assign set_core = {3'b000, ext_edge[2], ext_edge[1], ext_edge[0], pb_change, t0_wrap};

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops before any use
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_meta_r <= 3'b000;
            ext_sync_r <= 3'b000;
            ext_prev_r <= 3'b000;
            pb_meta_r <= 4'h0;
            pb_sync_r <= 4'h0;
            pb_prev_r <= 4'h0;
            pin_prev_valid_r <= 1'b0;
            pin_fill_r <= 2'b00;
        end else begin
            ext_meta_r <= ext_irq_pin_i;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
            pb_meta_r <= port_b_hi_pin_i;
            pb_sync_r <= pb_meta_r;
            pb_prev_r <= pb_sync_r;
            // Suppress false edges until meta, sync and prev all hold the pin
            pin_fill_r <= {pin_fill_r[0], 1'b1};
            pin_prev_valid_r <= pin_fill_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes and sticky flags
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_one_r <= `PIFP_RST_FLAGS;
            peripheral_flags_two_r <= `PIFP_RST_FLAGS;
            peripheral_enables_one_r <= `PIFP_RST_ENABLES;
            peripheral_enables_two_r <= `PIFP_RST_ENABLES;
            peripheral_priority_one_r <= `PIFP_RST_PRIORITY_ONE;
            peripheral_priority_two_r <= `PIFP_RST_PRIORITY_TWO;
            core_ctrl_r <= `PIFP_RST_CORE_CTRL;
            core_flags_r <= `PIFP_RST_FLAGS;
            core_prio_r <= `PIFP_RST_CORE_PRIO;
        end else begin
            flags_one_r <= sticky(flags_one_r, set_one,
                wr_any && reg_addr_i == `PIFP_OFF_FLAGS_ONE, reg_wdata_i, `PIFP_MASK_ONE);
            // sticky second flags, upper bits held zero
            peripheral_flags_two_r <= sticky(peripheral_flags_two_r, set_two,
                wr_any && reg_addr_i == `PIFP_OFF_FLAGS_TWO, reg_wdata_i, `PIFP_MASK_TWO);
            core_flags_r <= sticky(core_flags_r, set_core,
                wr_any && reg_addr_i == `PIFP_OFF_CORE_FLAGS, reg_wdata_i, 8'h1F);
            if (wr_any) begin
                case (reg_addr_i)
                    `PIFP_OFF_ENABLES_ONE: begin
                        peripheral_enables_one_r <= reg_wdata_i & `PIFP_MASK_ONE;
                    end
                    `PIFP_OFF_ENABLES_TWO: begin
                        peripheral_enables_two_r <= reg_wdata_i & `PIFP_MASK_TWO;
                    end
                    `PIFP_OFF_PRIORITY_ONE: begin
                        peripheral_priority_one_r <= reg_wdata_i & `PIFP_MASK_ONE;
                    end
                    `PIFP_OFF_PRIORITY_TWO: begin
                        peripheral_priority_two_r <= reg_wdata_i & `PIFP_MASK_TWO;
                    end
                    `PIFP_OFF_CORE_CTRL: begin
                        core_ctrl_r <= reg_wdata_i;
                    end
                    `PIFP_OFF_CORE_PRIO: begin
                        core_prio_r <= reg_wdata_i & 8'h7F;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request formation
    wire global_irq_enable = core_ctrl_r[`PIFP_CC_GIE];
    wire peripheral_irq_enable = core_ctrl_r[`PIFP_CC_PERIPHERAL_IRQ_ENABLE];
    wire plen = core_ctrl_r[`PIFP_CC_PLEN];
    wire [10:0] per_act;
    wire [10:0] per_pri;
    wire [4:0] core_act;
    wire [4:0] core_pri;
    wire per_gate;
    assign per_act = {flags_one_r[6:0] & peripheral_enables_one_r[6:0],
                      peripheral_flags_two_r[3:0] & peripheral_enables_two_r[3:0]};
    assign per_pri = {peripheral_priority_one_r[6:0], peripheral_priority_two_r[3:0]};
    // timer-0 gate; port change gate; clearing enable disables
    assign core_act = core_flags_r[4:0] & {core_ctrl_r[`PIFP_CC_X2IE],
        core_ctrl_r[`PIFP_CC_X1IE], core_ctrl_r[`PIFP_CC_X0IE],
        core_ctrl_r[`PIFP_CC_PBIE], core_ctrl_r[`PIFP_CC_T0IE]};
    // ext0 fixed high, ext1/ext2 by own bits
    assign core_pri = {core_prio_r[`PIFP_CP_X2IP], core_prio_r[`PIFP_CP_X1IP], 1'b1,
                       core_prio_r[`PIFP_CP_PBIP], core_prio_r[`PIFP_CP_T0IP]};
    // peripheral enable needed in compatibility mode
    assign per_gate = plen | peripheral_irq_enable;
    wire any_core = |core_act;
    wire any_per = per_gate & (|per_act);
    // priority bits only count with levels on
    wire hi_pend = plen ? (|(core_act & core_pri)) | (|(per_act & per_pri))
                        : (any_core | any_per);
    wire lo_pend = plen & ((|(core_act & ~core_pri)) | (|(per_act & ~per_pri)));
    // external wake enables armed on entry to sleep; core and peripheral requests use live enables
    wire wake_now = (|(core_flags_r[4:2] & ext_en_sleep_r)) | any_core | any_per | lo_pend;

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_en_sleep_r <= 3'b000;
            sleep_prev_r <= 1'b0;
        end else begin
            sleep_prev_r <= sleep_i;
            // latch external enables at sleep entry
            if (sleep_i && !sleep_prev_r) begin
                ext_en_sleep_r <= {core_ctrl_r[`PIFP_CC_X2IE], core_ctrl_r[`PIFP_CC_X1IE],
                                   core_ctrl_r[`PIFP_CC_X0IE]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core-facing outputs
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_high_o <= 1'b0;
            irq_low_o <= 1'b0;
            wake_o <= 1'b0;
            vector_en_o <= 1'b0;
            stack_push_o <= 1'b0;
            stack_pc_o <= 21'h000000;
        end else begin
            irq_high_o <= global_irq_enable & hi_pend;
            irq_low_o <= global_irq_enable & lo_pend & ~hi_pend;
            wake_o <= sleep_i & wake_now;
            // vector after wake only with global enable
            vector_en_o <= global_irq_enable;
            stack_push_o <= irq_ack_i;
            if (irq_ack_i) begin
                stack_pc_o <= return_pc_i;
            end
        end
    end

    pifp_shadow u_shadow (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .capture_i(irq_ack_i),
        .working_register_i(working_register_i),
        .status_i(status_i),
        .bank_select_register_i(bank_select_register_i),
        .shadow_o(fast_shadow_w)
    );
    // Output taken straight from the shadow flops, no second copy to keep in step
    always @* begin
        fast_shadow_o = fast_shadow_w;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after strobe
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `PIFP_OFF_FLAGS_ONE: reg_rdata_o <= flags_one_r;
                `PIFP_OFF_FLAGS_TWO: reg_rdata_o <= peripheral_flags_two_r;
                `PIFP_OFF_ENABLES_ONE: reg_rdata_o <= peripheral_enables_one_r;
                `PIFP_OFF_ENABLES_TWO: reg_rdata_o <= peripheral_enables_two_r;
                `PIFP_OFF_PRIORITY_ONE: reg_rdata_o <= peripheral_priority_one_r;
                `PIFP_OFF_PRIORITY_TWO: reg_rdata_o <= peripheral_priority_two_r;
                `PIFP_OFF_CORE_CTRL: reg_rdata_o <= core_ctrl_r;
                `PIFP_OFF_CORE_FLAGS: reg_rdata_o <= core_flags_r;
                `PIFP_OFF_CORE_PRIO: reg_rdata_o <= core_prio_r;
                `PIFP_OFF_STATUS: reg_rdata_o <= {4'h0, ext_en_sleep_r, sleep_prev_r};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule

// File: sim/pifp_sva.sv
// Port-level checker for the peripheral interrupt flag block
`timescale 1ns/10ps
`include "pifp_defines.vh"
module pifp_sva (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire sleep_i,
    input wire irq_ack_i,
    input wire [20:0] return_pc_i,
    input wire [7:0] working_register_i,
    input wire [7:0] status_i,
    input wire [7:0] bank_select_register_i,
    input wire irq_high_o,
    input wire irq_low_o,
    input wire wake_o,
    input wire vector_en_o,
    input wire stack_push_o,
    input wire [20:0] stack_pc_o,
    input wire [23:0] fast_shadow_o
);
// One clock domain, so one default clock and reset
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!rst_b_i);
////////////////////////////////////////////////////////////////
a_entry_push: assert property (irq_ack_i |=> stack_push_o &&
    stack_pc_o == $past(return_pc_i))
    else $error("return address not pushed after entry");
a_push_cause: assert property (!irq_ack_i |=> !stack_push_o)
    else $error("push without an entry");
a_shadow_copy: assert property (irq_ack_i |=> fast_shadow_o ==
    {$past(bank_select_register_i), $past(status_i), $past(working_register_i)})
    else $error("fast shadow does not hold entry context");
a_shadow_hold: assert property (!irq_ack_i |=> $stable(fast_shadow_o))
    else $error("fast shadow changed outside entry");
a_wake_asleep: assert property (!sleep_i |=> !wake_o)
    else $error("wake raised while awake");
a_one_level: assert property (!(irq_high_o && irq_low_o))
    else $error("both request levels raised");
a_vector_gate: assert property (reg_wr_i && reg_addr_i == `PIFP_OFF_CORE_CTRL
    |=> ##1 vector_en_o == $past(reg_wdata_i[7], 2))
    else $error("vector enable does not follow global enable");
a_top_bit: assert property (reg_rd_i && reg_addr_i inside {[4'h1:4'h5]}
    |=> !reg_rdata_o[7])
    else $error("unimplemented top bit read as one");
a_upper_nibble: assert property (reg_rd_i && reg_addr_i inside {4'h1, 4'h3, 4'h5}
    |=> reg_rdata_o[7:4] == 4'h0)
    else $error("unimplemented upper bits read as one");
endmodule
bind pifp_top pifp_sva u_sva (.*);

// File: sim/pifp_core_model.sv
// Core-side model: takes requests and supplies the context to be saved
`timescale 1ns/10ps
module pifp_core_model (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire irq_high_i,
    input wire irq_low_i,
    input wire ack_en_i,
    input wire slow_i,
    output reg irq_ack_o,
    output reg [20:0] return_pc_o,
    output reg [7:0] working_register_o,
    output reg [7:0] status_o,
    output reg [7:0] bank_select_register_o
);
reg [2:0] wait_r;
reg busy_r;
////////////////////////////////////////////////////////////////
// Entry after zero or three cycles; one entry per ack_en_i window
always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        irq_ack_o <= 1'b0;
        busy_r <= 1'b0;
        wait_r <= 3'h0;
        {return_pc_o, working_register_o, status_o, bank_select_register_o} <= 45'h0;
    end else begin
        irq_ack_o <= 1'b0;
        if (!busy_r) begin
            {return_pc_o, working_register_o, status_o, bank_select_register_o} <=
                {return_pc_o, working_register_o, status_o, bank_select_register_o} +
                45'h0123456789B;
        end
        if (!busy_r && ack_en_i && (irq_high_i || irq_low_i)) begin
            if (wait_r == (slow_i ? 3'h3 : 3'h0)) begin
                irq_ack_o <= 1'b1;
                busy_r <= 1'b1;
            end else begin
                wait_r <= wait_r + 3'h1;
            end
        end
        if (busy_r && !ack_en_i) begin
            busy_r <= 1'b0;
            wait_r <= 3'h0;
        end
    end
end
endmodule

// File: sim/pifp_top_bench.sv
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module pifp_top_bench;
typedef struct packed {logic [10:0] ev; logic [3:0] adr; logic [7:0] msk;} pifp_row_t;
logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, pwm = 1'b0, tick = 1'b0, t16 = 1'b0;
logic sleep = 1'b0, ack_en = 1'b0, slow = 1'b0;
logic [3:0] addr = 4'h0, pb = 4'h0;
logic [7:0] wdata = 8'h00;
logic [10:0] ev = 11'h000;
logic [15:0] t0cnt = 16'h0000;
logic [2:0] pin = 3'h0;
wire [7:0] rdata, working_register, st, bank_select_register;
wire hi, lo, wake, vec, push, ack;
wire [20:0] spc, pc;
wire [23:0] shd;
int failures = 0, n_checks = 0, cyc = 0, k;
logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h0F};
logic [7:0] msk_v [6] = '{8'h00, 8'h0F, 8'h7F, 8'h0F, 8'h7F, 8'h0F};
// Event bits: 10 bus collision, 9 low voltage, 8 timer 3, 7 ccp2, 6..0 flags one
pifp_row_t rows [11] = '{'{11'h001, 4'h0, 8'h01}, '{11'h002, 4'h0, 8'h02},
    '{11'h004, 4'h0, 8'h04}, '{11'h008, 4'h0, 8'h08}, '{11'h010, 4'h0, 8'h10},
    '{11'h020, 4'h0, 8'h20}, '{11'h040, 4'h0, 8'h40}, '{11'h080, 4'h1, 8'h01},
    '{11'h100, 4'h1, 8'h02}, '{11'h200, 4'h1, 8'h04}, '{11'h400, 4'h1, 8'h08}};
////////////////////////////////////////////////////////////////
pifp_top dut (.clk_sys_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .adc_done_evt_i(ev[6]),
    .serial_rx_full_i(ev[5]), .serial_tx_empty_i(ev[4]), .sync_port_evt_i(ev[3]),
    .ccp1_evt_i(ev[2]), .timer2_match_evt_i(ev[1]), .timer1_ovf_evt_i(ev[0]),
    .bus_collision_evt_i(ev[10]), .low_voltage_evt_i(ev[9]), .timer3_ovf_evt_i(ev[8]),
    .ccp2_evt_i(ev[7]), .ccp2_pwm_mode_i(pwm), .timer0_tick_i(tick), .timer0_count_i(t0cnt),
    .timer0_16bit_i(t16), .ext_irq_pin_i(pin), .port_b_hi_pin_i(pb), .sleep_i(sleep),
    .irq_ack_i(ack), .return_pc_i(pc), .working_register_i(working_register), .status_i(st),
    .bank_select_register_i(bank_select_register), .irq_high_o(hi), .irq_low_o(lo), .wake_o(wake),
    .vector_en_o(vec), .stack_push_o(push), .stack_pc_o(spc), .fast_shadow_o(shd));
pifp_core_model core (.clk_sys_i(clk), .rst_b_i(rst_b), .irq_high_i(hi), .irq_low_i(lo),
    .ack_en_i(ack_en), .slow_i(slow), .irq_ack_o(ack), .return_pc_o(pc),
    .working_register_o(working_register), .status_o(st), .bank_select_register_o(bank_select_register));
////////////////////////////////////////////////////////////////
// Clock and hang guard; the ceiling is over ten times the expected run
initial begin
    forever #12.5 clk = ~clk;
end
always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
        failures++;
        $display("mismatch at %0t: run did not finish", $time);
        tally_and_finish();
    end
end
// Bus, stimulus and verdict tasks; each bus cycle is one strobe cycle
task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
endtask
task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata & m, e)
endtask
task automatic evp(input logic [10:0] v, input logic p);
    @(posedge clk);
    ev <= v;
    pwm <= p;
    @(posedge clk);
    ev <= 11'h000;
    pwm <= 1'b0;
endtask
task automatic t0p(input logic [15:0] c, input logic m);
    @(posedge clk);
    tick <= 1'b1;
    t0cnt <= c;
    t16 <= m;
    @(posedge clk);
    tick <= 1'b0;
endtask
task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
        $display("TEST PASSED");
    end else begin
        $display("TEST FAILED");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////
initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(i[3:0], 8'hFF, rst_v[i]);
    for (int i = 1; i < 6; i++) begin
        wr_reg(i[3:0], 8'hFF);
        rdc(i[3:0], 8'hFF, msk_v[i]);
        wr_reg(i[3:0], 8'h00);
        rdc(i[3:0], 8'hFF, 8'h00);
    end
    wr_reg(4'hF, 8'hFF);
    rdc(4'hF, 8'hFF, 8'h00);
    $display("done: register map");
    // Flags set with every enable closed, and ccp2 ignored in pwm mode
    evp(11'h400, 1'b0);
    tk(2);
    `CHK(hi, 1'b0)
    rdc(4'h1, 8'hFF, 8'h08);
    wr_reg(4'h1, 8'h00);
    evp(11'h080, 1'b1);
    rdc(4'h1, 8'h01, 8'h00);
    wr_reg(4'h2, 8'h7F);
    wr_reg(4'h3, 8'h0F);
    wr_reg(4'h4, 8'h7F);
    wr_reg(4'h5, 8'h0F);
    wr_reg(4'h6, 8'hC1);
    foreach (rows[i]) begin
        evp(rows[i].ev, 1'b0);
        rdc(rows[i].adr, rows[i].msk, rows[i].msk);
        `CHK(hi, 1'b1)
        wr_reg(rows[i].adr, 8'h00);
    end
    // Set and software clear in one cycle: the set wins
    @(posedge clk);
    wr <= 1'b1;
    addr <= 4'h1;
    wdata <= 8'h00;
    ev <= 11'h400;
    @(posedge clk);
    wr <= 1'b0;
    ev <= 11'h000;
    rdc(4'h1, 8'h08, 8'h08);
    $display("done: event flags");
    // Low priority, then single-level mode with and without the peripheral gate
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h5, 8'h00);
    evp(11'h400, 1'b0);
    tk(2);
    `CHK({hi, lo}, 2'b01)
    wr_reg(4'h6, 8'h80);
    tk(2);
    `CHK({hi, lo}, 2'b00)
    wr_reg(4'h6, 8'hC0);
    tk(2);
    `CHK({hi, lo}, 2'b10)
    // Entry taken promptly and after a delay
    for (int s = 0; s < 2; s++) begin
        @(posedge clk);
        slow <= s[0];
        ack_en <= 1'b1;
        k = 0;
        while (push !== 1'b1 && k < 20) begin
            tk(1);
            k++;
        end
        `CHK(push, 1'b1)
        `CHK(spc, pc)
        `CHK(shd, {bank_select_register, st, working_register})
        @(posedge clk);
        ack_en <= 1'b0;
        tk(2);
    end
    wr_reg(4'h1, 8'h00);
    $display("done: priority and entry");
    // External pins: pin 0 rising, pin 1 falling only
    wr_reg(4'h8, 8'h1F);
    @(posedge clk);
    pin <= 3'b011;
    tk(6);
    rdc(4'h7, 8'h0C, 8'h04);
    @(posedge clk);
    pin <= 3'b001;
    tk(6);
    rdc(4'h7, 8'h0C, 8'h0C);
    wr_reg(4'h7, 8'h04);
    $display("done: external pins");
    // Timer-0 wrap in both widths, then port-B change
    t0p(16'h00FF, 1'b0);
    rdc(4'h7, 8'h01, 8'h01);
    wr_reg(4'h7, 8'h04);
    t0p(16'h00FF, 1'b1);
    rdc(4'h7, 8'h01, 8'h00);
    t0p(16'hFFFF, 1'b1);
    rdc(4'h7, 8'h01, 8'h01);
    @(posedge clk);
    pb <= 4'h8;
    tk(6);
    rdc(4'h7, 8'h02, 8'h02);
    wr_reg(4'h6, 8'hA1);
    tk(2);
    `CHK({hi, lo}, 2'b10)
    wr_reg(4'h8, 8'h1E);
    tk(2);
    `CHK({hi, lo}, 2'b01)
    // Pin 0 stays high priority with every core priority bit low
    wr_reg(4'h8, 8'h10);
    wr_reg(4'h6, 8'h89);
    tk(2);
    `CHK({hi, lo}, 2'b10)
    $display("done: timer and port change");
    // Wake from sleep by pin 0, vectoring only with the global enable
    wr_reg(4'h6, 8'h08);
    @(posedge clk);
    sleep <= 1'b1;
    tk(3);
    `CHK(wake, 1'b1)
    `CHK(vec, 1'b0)
    wr_reg(4'h6, 8'h88);
    tk(1);
    `CHK(vec, 1'b1)
    @(posedge clk);
    sleep <= 1'b0;
    tk(2);
    $display("done: wake");
    // Reset in mid-run with pins held high: reset values, no false pin edge
    @(posedge clk);
    rst_b <= 1'b0;
    tk(2);
    `CHK({hi, lo, wake, vec, push}, 5'h00)
    @(posedge clk);
    rst_b <= 1'b1;
    rdc(4'h4, 8'hFF, 8'h7F);
    rdc(4'h7, 8'hFF, 8'h00);
    tk(4);
    rdc(4'h7, 8'hFF, 8'h00);
    $display("done: mid-run reset");
    tally_and_finish();
end
endmodule
